// *** pkg/acc_pkg.sv ***
// Package: register map, field layout, reset values and carrier types of the calibration control
package acc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_FG_SETUP = 8'h62;
	localparam logic [7:0] IDX_OFS_REF = 8'h65;
	localparam logic [7:0] IDX_AVG_CFG = 8'h68;
	localparam logic [7:0] IDX_CAL_STATUS = 8'h6a;
	localparam logic [7:0] IDX_PIN_CFG = 8'h6b;
	localparam logic [7:0] IDX_SOFT_TRIG = 8'h6c;

	// Word index field of the byte address
	localparam int ADDR_IDX_LSB = 2;
	localparam int ADDR_IDX_MSB = 9;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] RST_FG_SETUP = 8'h01;
	localparam logic [7:0] RST_OFS_REF = 8'h01;
	localparam logic [7:0] RST_AVG_CFG = 8'h61;
	localparam logic [7:0] RST_CAL_STATUS = 8'h00;
	localparam logic [7:0] RST_PIN_CFG = 8'h00;
	localparam logic [7:0] RST_SOFT_TRIG = 8'h01;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int FG_SEL_BIT = 0;
	localparam int BG_EN_BIT = 1;
	localparam int OFS_REF_BIT = 2;
	localparam int OFS_AVG_LSB = 4;
	localparam int LIN_AVG_LSB = 0;
	localparam int AVG_W = 3;
	localparam int ST_FOREGROUND_COMPLETE_BIT = 0;
	localparam int ST_HALTED_BIT = 1;
	localparam int ST_CODE_LSB = 2;
	localparam int TRIG_SRC_BIT = 0;
	localparam int PIN_SEL_LSB = 1;
	localparam int SOFT_TRIG_BIT = 0;

	// Status pin source codes
	localparam logic [1:0] PIN_SEL_FOREGROUND_COMPLETE = 2'h0;
	localparam logic [1:0] PIN_SEL_HALTED = 2'h1;
	localparam logic [1:0] PIN_SEL_ALARM = 2'h2;
	localparam logic [1:0] PIN_SEL_LOW = 2'h3;

	// AHB-Lite transfer encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	// Synchroniser depth for the trigger pin
	localparam int SYNC_STAGES = 2;

	////////////////////////////////////////////////////////////////////////////
	// Calibration sequencer states, Gray coded along the path
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_CLEAR = 2'b01,
		ACC_RUN_FG = 2'b11,
		ACC_DONE = 2'b10
	} acc_state_t;

	// Controls handed to the calibration engine
	typedef struct packed {
		logic clearCalValues;
		logic runForeground;
		logic backgroundCalEnable;
		logic offsetRefSelect;
		logic [2:0] offsetAveraging;
		logic [2:0] linearityAveraging;
		logic calTrigger;
	} acc_ctrl_t;

	// Events and state reported by the calibration engine
	typedef struct packed {
		logic foregroundDone;
		logic backgroundStopped;
		logic backgroundResumed;
		logic alarm;
		logic [2:0] statusCode;
	} acc_evt_t;

endpackage

// *** hw/acc_sync.sv ***
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module acc_sync
	import acc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic asyncIn,
	output logic syncOut
);
	logic [SYNC_STAGES-1:0] stage_q;

	////////////////////////////////////////////////////////////////////////////
	// Shift chain; only the last stage is seen outside
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage_q <= '0;
		end else begin
			stage_q <= {stage_q[SYNC_STAGES-2:0], asyncIn};
		end
	end

	assign syncOut = stage_q[SYNC_STAGES-1];
endmodule // acc_sync

// *** hw/acc_regs.sv ***
// Calibration control and status registers behind an AHB-Lite slave
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
// Function
// - Foreground select clears stored values, then runs or skips foreground calibration.
// - Offset reference 0 trims each converter toward mid-code, zero offset.
// - Offset reference 1 matches primary offsets to the stand-in spare converter.
// - Offset averaging field bits 6:4, reset 6, larger means more averaging.
// - Linearity averaging field bits 2:0, reset 1, larger means more averaging.
// - Background-halted bit reads 1 once calibration stopped at requested phase.
// - Background-halted bit returns to 0 when calibration resumes.
// - Background disabled: halted bit sets when foreground finishes or is skipped.
// - Foreground-complete bit 0 high once foreground finished or was skipped.
// - Pin select bits 2:1 choose complete, halted, alarm or low for status pin.
// - Trigger source 1 uses hardware pin, ignores software trigger bit.
// - Status register is read-only; writes have no effect.
// - Background enable bit lets converters calibrate during operation; reset clear.
// - Software trigger bit stands in for the pin while source select is 0.
module acc_regs
	import acc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic hardwareTriggerPin,
	input wire acc_evt_t engineEvt,
	output acc_ctrl_t engineCtrl,
	output logic statusOutputPin
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0] fgSetup_q;
	logic [7:0] ofsRef_q;
	logic [7:0] avgCfg_q;
	logic [7:0] pinCfg_q;
	logic [7:0] softTrig_q;
	logic [2:0] statusCode_q;
	logic fgComplete_q;
	logic fgComplete_d;
	logic bgHalted_q;
	logic bgHalted_d;
	logic wrPend_q;
	logic [7:0] wrIdx_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic restartPend_q;
	logic calTrigger_q;
	logic calTrigger_d;
	logic statusPin_q;
	logic statusPin_d;
	acc_state_t state_q;
	acc_state_t state_d;
	logic hwTrigSync;
	logic addrPhase;
	logic [7:0] reqIdx;
	logic rdTake;
	logic wrTake;
	logic wrFgSetup;
	logic wrOfsRef;
	logic wrAvgCfg;
	logic wrPinCfg;
	logic wrSoftTrig;
	logic [7:0] wrByte;
	logic [7:0] statusByte;
	logic fgSelect;
	logic bgEnable;
	logic trigFromPin;
	logic [1:0] pinSel;
	logic enterClear;
	logic enterDone;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode; zero wait states, so the slave is always ready and OKAY
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign hrdata = rdata_q;
	assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign reqIdx = haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
	assign rdTake = addrPhase && !hwrite;
	assign wrTake = addrPhase && hwrite;
	assign wrByte = hwdata[7:0];

	// Write strobes in the data phase; the status index has none at all
	assign wrFgSetup = wrPend_q && (wrIdx_q == IDX_FG_SETUP);
	assign wrOfsRef = wrPend_q && (wrIdx_q == IDX_OFS_REF);
	assign wrAvgCfg = wrPend_q && (wrIdx_q == IDX_AVG_CFG);
	assign wrPinCfg = wrPend_q && (wrIdx_q == IDX_PIN_CFG);
	assign wrSoftTrig = wrPend_q && (wrIdx_q == IDX_SOFT_TRIG);

	// Field views
	assign fgSelect = fgSetup_q[FG_SEL_BIT];
	assign bgEnable = fgSetup_q[BG_EN_BIT];
	assign trigFromPin = pinCfg_q[TRIG_SRC_BIT];
	assign pinSel = pinCfg_q[PIN_SEL_LSB +: 2];

	// Status byte as software sees it; upper bits read zero
	assign statusByte = {3'h0, statusCode_q, bgHalted_q, fgComplete_q};

	////////////////////////////////////////////////////////////////////////////
	// Address phase capture for a write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPend_q <= 1'b0;
			wrIdx_q <= 8'h00;
		end else begin
			wrPend_q <= wrTake;
			wrIdx_q <= reqIdx;
		end
	end

	// Read mux, registered so data stand for the whole data phase
	always_comb begin
		rdata_d = rdata_q;
		if (rdTake) begin
			case (reqIdx)
				IDX_FG_SETUP: rdata_d = {24'h000000, fgSetup_q};
				IDX_OFS_REF: rdata_d = {24'h000000, ofsRef_q};
				IDX_AVG_CFG: rdata_d = {24'h000000, avgCfg_q};
				IDX_CAL_STATUS: rdata_d = {24'h000000, statusByte};
				IDX_PIN_CFG: rdata_d = {24'h000000, pinCfg_q};
				IDX_SOFT_TRIG: rdata_d = {24'h000000, softTrig_q};
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Writable registers; reserved bits are stored as written, since
	// software is expected to write them back at reset values
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fgSetup_q <= RST_FG_SETUP;
			ofsRef_q <= RST_OFS_REF;
		end else begin
			if (wrFgSetup) begin
				fgSetup_q <= wrByte;
			end
			if (wrOfsRef) begin
				ofsRef_q <= wrByte;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avgCfg_q <= RST_AVG_CFG;
			pinCfg_q <= RST_PIN_CFG;
			softTrig_q <= RST_SOFT_TRIG;
		end else begin
			if (wrAvgCfg) begin
				avgCfg_q <= wrByte;
			end
			if (wrPinCfg) begin
				pinCfg_q <= wrByte;
			end
			if (wrSoftTrig) begin
				softTrig_q <= wrByte;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Calibration sequencer. A restart is pending out of reset and after
	// every write of the foreground setup register, so a new setting
	// always begins with cleared calibration values.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			restartPend_q <= 1'b1;
		end else if (wrFgSetup) begin
			restartPend_q <= 1'b1;
		end else if (state_q == ACC_CLEAR) begin
			restartPend_q <= 1'b0;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			ACC_IDLE: begin
				if (restartPend_q) begin
					state_d = ACC_CLEAR;
				end
			end
			ACC_CLEAR: begin
				// Values are cleared either way; foreground run only if selected
				if (wrFgSetup) begin
					state_d = ACC_CLEAR;
				end else if (fgSelect) begin
					state_d = ACC_RUN_FG;
				end else begin
					state_d = ACC_DONE;
				end
			end
			ACC_RUN_FG: begin
				if (restartPend_q || wrFgSetup) begin
					state_d = ACC_IDLE;
				end else if (engineEvt.foregroundDone) begin
					state_d = ACC_DONE;
				end
			end
			ACC_DONE: begin
				if (restartPend_q || wrFgSetup) begin
					state_d = ACC_IDLE;
				end
			end
			default: state_d = ACC_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ACC_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	assign enterClear = (state_d == ACC_CLEAR) && (state_q != ACC_CLEAR);
	assign enterDone = (state_d == ACC_DONE) && (state_q != ACC_DONE);

	////////////////////////////////////////////////////////////////////////////
	// Status flags. Halted: a stop event wins over a restart clear or a
	// resume in the same cycle, so a completed stop is never lost.
	always_comb begin
		fgComplete_d = fgComplete_q;
		if (enterClear) begin
			fgComplete_d = 1'b0;
		end else if (enterDone) begin
			fgComplete_d = 1'b1;
		end
	end

	always_comb begin
		bgHalted_d = bgHalted_q;
		if (bgEnable && engineEvt.backgroundStopped) begin
			bgHalted_d = 1'b1;
		end else if (enterClear) begin
			bgHalted_d = 1'b0;
		end else if (bgEnable && engineEvt.backgroundResumed) begin
			bgHalted_d = 1'b0;
		end else if (!bgEnable && enterDone) begin
			bgHalted_d = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fgComplete_q <= RST_CAL_STATUS[ST_FOREGROUND_COMPLETE_BIT];
			bgHalted_q <= RST_CAL_STATUS[ST_HALTED_BIT];
			statusCode_q <= RST_CAL_STATUS[ST_CODE_LSB +: 3];
		end else begin
			fgComplete_q <= fgComplete_d;
			bgHalted_q <= bgHalted_d;
			statusCode_q <= engineEvt.statusCode;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Trigger pin synchroniser and trigger source selection
	acc_sync u_trig_sync (
		.clk(clk),
		.rst(rst),
		.asyncIn(hardwareTriggerPin),
		.syncOut(hwTrigSync)
	);

	always_comb begin
		if (trigFromPin) begin
			calTrigger_d = hwTrigSync;
		end else begin
			calTrigger_d = softTrig_q[SOFT_TRIG_BIT];
		end
	end

	// Status pin source; registered so the pin never glitches
	always_comb begin
		case (pinSel)
			PIN_SEL_FOREGROUND_COMPLETE: statusPin_d = fgComplete_q;
			PIN_SEL_HALTED: statusPin_d = bgHalted_q;
			PIN_SEL_ALARM: statusPin_d = engineEvt.alarm;
			PIN_SEL_LOW: statusPin_d = 1'b0;
			default: statusPin_d = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			calTrigger_q <= RST_SOFT_TRIG[SOFT_TRIG_BIT];
			statusPin_q <= 1'b0;
		end else begin
			calTrigger_q <= calTrigger_d;
			statusPin_q <= statusPin_d;
		end
	end

	assign statusOutputPin = statusPin_q;

	////////////////////////////////////////////////////////////////////////////
	// Engine controls; the reference choice selects mid-code or spare
	// converter matching inside the engine
	assign engineCtrl.clearCalValues = (state_q == ACC_CLEAR);
	assign engineCtrl.runForeground = (state_q == ACC_RUN_FG);
	assign engineCtrl.backgroundCalEnable = bgEnable;
	assign engineCtrl.offsetRefSelect = ofsRef_q[OFS_REF_BIT];
	assign engineCtrl.offsetAveraging = avgCfg_q[OFS_AVG_LSB +: AVG_W];
	assign engineCtrl.linearityAveraging = avgCfg_q[LIN_AVG_LSB +: AVG_W];
	assign engineCtrl.calTrigger = calTrigger_q;

endmodule // acc_regs

// *** verification/acc_regs_monitor.sv ***
// Port checker for the calibration control registers
`timescale 1ns/1ps
module acc_regs_monitor
	import acc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic hardwareTriggerPin,
	input wire acc_evt_t engineEvt,
	input wire acc_ctrl_t engineCtrl,
	input wire logic statusOutputPin
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////
	// Shadow of write data phases, so each field change has a known cause
	logic wrQ;
	logic [7:0] idxQ;
	logic [2:0] pinQ;
	logic softQ;
	wire takeWr = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
	wire wrFg = wrQ && idxQ == IDX_FG_SETUP;
	wire wrOfs = wrQ && idxQ == IDX_OFS_REF;
	wire wrAvg = wrQ && idxQ == IDX_AVG_CFG;
	wire wrPin = wrQ && idxQ == IDX_PIN_CFG;
	wire wrSoft = wrQ && idxQ == IDX_SOFT_TRIG;

	// Mirrors only the bits the mux and trigger checks need
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrQ <= 1'b0;
			idxQ <= 8'h00;
			pinQ <= 3'h0;
			softQ <= 1'b1;
		end else begin
			wrQ <= takeWr;
			idxQ <= haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
			if (wrPin) pinQ <= hwdata[2:0];
			if (wrSoft) softQ <= hwdata[SOFT_TRIG_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer and field checks
	a_clear_single: assert property (engineCtrl.clearCalValues |=> !engineCtrl.clearCalValues)
		else $error("clear pulse longer than one cycle");
	a_run_after_clear: assert property ($rose(engineCtrl.runForeground) |-> $past(engineCtrl.clearCalValues))
		else $error("foreground run without clear");
	a_done_ends_run: assert property (engineCtrl.runForeground && engineEvt.foregroundDone |=> !engineCtrl.runForeground)
		else $error("foreground run kept after done");
	a_avg_fields: assert property (wrAvg |=> {engineCtrl.offsetAveraging, engineCtrl.linearityAveraging} == {$past(hwdata[6:4]), $past(hwdata[2:0])})
		else $error("averaging fields not taken");
	a_ofs_ref: assert property (wrOfs |=> engineCtrl.offsetRefSelect == $past(hwdata[OFS_REF_BIT]))
		else $error("offset reference not taken");
	a_bg_enable: assert property (wrFg |=> engineCtrl.backgroundCalEnable == $past(hwdata[BG_EN_BIT]))
		else $error("background enable not taken");
	a_pin_alarm: assert property ($past(pinQ[2:1]) == PIN_SEL_ALARM |-> statusOutputPin == $past(engineEvt.alarm))
		else $error("status pin does not follow alarm");
	a_pin_low: assert property ($past(pinQ[2:1]) == PIN_SEL_LOW |-> !statusOutputPin)
		else $error("status pin not low");
	a_hw_trigger: assert property ($past(pinQ[TRIG_SRC_BIT]) |-> engineCtrl.calTrigger == $past(hardwareTriggerPin, 3))
		else $error("trigger does not follow pin");
	a_sw_trigger: assert property (!$past(pinQ[TRIG_SRC_BIT]) |-> engineCtrl.calTrigger == $past(softQ))
		else $error("trigger does not follow software bit");
endmodule // acc_regs_monitor

bind acc_regs acc_regs_monitor acc_regs_monitor_i (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
	.hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .hardwareTriggerPin, .engineEvt,
	.engineCtrl, .statusOutputPin);

// *** verification/test_adc_calibration_control.sv ***
// Self-checking bench for the calibration control registers
`timescale 1ns/1ps
module test_adc_calibration_control
	import acc_pkg::*;
;
	logic clk, rst, hsel, hwrite, hready, hresp, pin, spin;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	acc_evt_t evt;
	acc_ctrl_t ctrl;
	int errors, compares;
	logic [7:0] regIdx [5] = '{IDX_FG_SETUP, IDX_OFS_REF, IDX_AVG_CFG, IDX_PIN_CFG, IDX_SOFT_TRIG};
	logic [7:0] regRst [5] = '{8'h01, 8'h01, 8'h61, 8'h00, 8'h01};
	logic [7:0] avgVal [3] = '{8'h35, 8'h70, 8'h07};
	logic [3:0] pinExp = 4'h5;

	// Slave's hreadyout is the bus's hready; word size only
	acc_regs acc_regs_i (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready, .hreadyout(hready), .hrdata, .hresp, .hardwareTriggerPin(pin),
		.engineEvt(evt), .engineCtrl(ctrl), .statusOutputPin(spin));

	////////////////////////////////////////////////////////////////////////////
	// Compare, wait and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Waits past the edge so its updates have landed
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One single AHB transfer, request held until hready is seen high
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {22'h000000, idx, 2'h0};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		do @(posedge clk); while (hready !== 1'b1);
		#1;
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00);
		chk(hrdata, {24'h000000, exp});
		chk(32'(hresp), 32'(HRESP_OKAY));
	endtask

	// Engine event pulse of one cycle
	task automatic pulse(input logic [6:0] m);
		@(posedge clk);
		evt <= evt | m;
		@(posedge clk);
		evt <= evt & ~m;
		wt(2);
	endtask

	task automatic conclude;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog; the tests need well under a thousand cycles
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#50000;
		errors++;
		conclude();
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		pin = 1'b0;
		evt = 7'h00;
		errors = 0;
		compares = 0;
		// Look after a clock edge in reset, so a missed time-zero edge of rst is harmless
		@(posedge clk);
		#1;
		chk(32'(ctrl), 32'h063);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wt(3);
		chk(32'(ctrl.runForeground), 32'h1);
		for (int i = 0; i < 5; i++) begin
			rd(regIdx[i], regRst[i]);
		end
		rd(IDX_CAL_STATUS, 8'h00);
		xfer(1'b1, 8'h70, 8'h5a);
		rd(8'h70, 8'h00);
		@(posedge clk);
		evt.statusCode <= 3'h5;
		pulse(7'h40);
		rd(IDX_CAL_STATUS, 8'h17);
		xfer(1'b1, IDX_CAL_STATUS, 8'h00);
		rd(IDX_CAL_STATUS, 8'h17);
		xfer(1'b1, IDX_FG_SETUP, 8'h02);
		wt(4);
		chk(32'({ctrl.runForeground, ctrl.backgroundCalEnable}), 32'h1);
		rd(IDX_CAL_STATUS, 8'h15);
		pulse(7'h20);
		rd(IDX_CAL_STATUS, 8'h17);
		pulse(7'h10);
		rd(IDX_CAL_STATUS, 8'h15);
		for (int i = 0; i < 3; i++) begin
			xfer(1'b1, IDX_AVG_CFG, avgVal[i]);
			chk(32'({ctrl.offsetAveraging, ctrl.linearityAveraging}), 32'({avgVal[i][6:4], avgVal[i][2:0]}));
			rd(IDX_AVG_CFG, avgVal[i]);
		end
		xfer(1'b1, IDX_OFS_REF, 8'h05);
		chk(32'(ctrl.offsetRefSelect), 32'h1);
		xfer(1'b1, IDX_OFS_REF, 8'h01);
		chk(32'(ctrl.offsetRefSelect), 32'h0);
		@(posedge clk);
		evt.alarm <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, IDX_PIN_CFG, {5'h00, i[1:0], 1'b0});
			wt(2);
			chk(32'(spin), 32'(pinExp[i]));
		end
		@(posedge clk);
		pin <= 1'b1;
		xfer(1'b1, IDX_SOFT_TRIG, 8'h00);
		wt(2);
		chk(32'(ctrl.calTrigger), 32'h0);
		xfer(1'b1, IDX_PIN_CFG, 8'h01);
		wt(4);
		chk(32'(ctrl.calTrigger), 32'h1);
		@(posedge clk);
		pin <= 1'b0;
		wt(2);
		chk(32'(ctrl.calTrigger), 32'h1);
		wt(1);
		chk(32'(ctrl.calTrigger), 32'h0);
		conclude();
	end
endmodule // test_adc_calibration_control
